// file: logic/residual_overvoltage_stages.sv
// two definite-time residual overvoltage stages with fault records
// Notes on behaviour
// - exceeding pick-up raises the stage start
// - exceedance lasting the delay raises trip
// - fundamental filter rejects third harmonic strongly
// - single line modes disable residual protection
// - residual-input mode scales by secondary voltage
// - low-set and high-set definite-time stages
// - four parameter groups, one active
// - group from inputs, virtual signals or manual
// - group source none, digital, virtual, lamp, output
// - start and trip counters, clearable
// - one test-forcing flag for all stages
// - forcing flag clears after five minutes
// - forced start/trip writes only while forcing
// - settings change only with password
// - status is idle, blocked, start or trip
// - residual value in percent of rated phase
// - pick-up in the same percent scale
// - keep the eight most recent fault records
// - elapsed delay in percent, 100 means trip
// - record time stamp date and milliseconds
// - record holds the active parameter group
`include "residual_ov_defs.svh"
`timescale 1ns/1ps
module residual_overvoltage_stages #(
  parameter int MS_CYCLES = `CLK_HZ / `MS_PER_S,
  parameter int FORCE_MS = `FORCE_TIMEOUT_MIN * `S_PER_MIN * `MS_PER_S,
  parameter int DEPTH = 8
)(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // measurement
  input wire logic signed [15:0] sample_i,
  input wire logic sample_valid_i,
  input wire residual_ov_pkg::voltage_mode_type voltage_mode_i,
  input wire logic [15:0] rated_gain_i,
  input wire logic [15:0] residual_transformer_secondary_i,
  input wire logic block_i,
  // settings
  input wire logic password_ok_i,
  input wire logic set_wr_i,
  input wire logic set_stage_i,
  input wire logic [1:0] set_group_i,
  input wire logic [15:0] set_pickup_i,
  input wire logic [19:0] set_delay_ms_i,
  // parameter group selection
  input wire residual_ov_pkg::group_source_type group_select_source_i,
  input wire logic [1:0] digital_group_i,
  input wire logic [1:0] virtual_input_n_i,
  input wire logic [1:0] indicator_lamp_n_i,
  input wire logic [1:0] virtual_output_n_i,
  input wire logic manual_group_wr_i,
  input wire logic [1:0] manual_group_i,
  // test forcing
  input wire logic force_set_i,
  input wire logic force_clr_i,
  input wire logic force_wr_i,
  input wire logic force_stage_i,
  input wire logic force_start_i,
  input wire logic force_trip_i,
  // counters and time
  input wire logic [1:0] start_cnt_clr_i,
  input wire logic [1:0] trip_cnt_clr_i,
  input wire logic [31:0] date_i,
  input wire logic [26:0] time_ms_i,
  // record read
  input wire logic rec_rd_i,
  input wire logic [2:0] rec_rd_idx_i,
  // results
  output logic [15:0] residual_voltage_value_o,
  output logic [1:0] start_o,
  output logic [1:0] trip_o,
  output residual_ov_pkg::stage_status_type stage_status_o [2],
  output logic [15:0] start_event_counter_o [2],
  output logic [15:0] trip_event_counter_o [2],
  output logic [1:0] active_parameter_group_o,
  output logic force_flag_o,
  output logic rec_valid_o,
  output logic [3:0] rec_count_o,
  output residual_ov_pkg::record_type rec_data_o
);
  localparam int NST = 2;
  localparam int AW = $clog2(DEPTH);
  localparam int MSW = $clog2(MS_CYCLES);
  localparam int FW = $clog2(FORCE_MS + 1);

  // fundamental sine coefficient, quarter-wave table
  function automatic logic signed [12:0] coef(input logic [3:0] i);
    logic [2:0] r;
    logic signed [12:0] v;
    r = i[2] ? 3'h4 - {1'b0, i[1:0]} : {1'b0, i[1:0]};
    case (r)
      3'h0: v = 13'sh0000;
      3'h1: v = 13'sh061F;
      3'h2: v = 13'sh0B50;
      3'h3: v = 13'sh0EC8;
      default: v = 13'sh0FFF;
    endcase
    coef = i[3] ? -v : v;
  endfunction

  function automatic logic [35:0] abs36(input logic signed [35:0] x);
    abs36 = x[35] ? 36'(-x) : 36'(x);
  endfunction

  // filter state
  logic [3:0] idx, next_idx;
  logic signed [35:0] acc_re, next_acc_re, acc_im, next_acc_im;
  logic signed [35:0] fin_re, next_fin_re, fin_im, next_fin_im;
  logic fin_valid, next_fin_valid;
  logic [15:0] next_value;

  // one-cycle correlation with sine and cosine cancels harmonics
  always_comb begin
    logic signed [35:0] s_re, s_im;
    logic [35:0] a, b, m;
    logic [39:0] p;
    s_re = acc_re + 36'(sample_i * coef(idx + `QUARTER));
    s_im = acc_im + 36'(sample_i * coef(idx));
    a = abs36(fin_re);
    b = abs36(fin_im);
    m = (a > b) ? a + (b >> 1) : b + (a >> 1);
    p = 40'(m[35:12]) * 40'(
      (voltage_mode_i == residual_ov_pkg::residual_input_mode) ?
      residual_transformer_secondary_i : rated_gain_i);
    next_idx = idx;
    next_acc_re = acc_re;
    next_acc_im = acc_im;
    next_fin_re = fin_re;
    next_fin_im = fin_im;
    next_fin_valid = 1'b0;
    next_value = residual_voltage_value_o;
    if (sample_valid_i) begin
      next_idx = idx + 4'h1;
      if (idx == `LAST_SAMPLE) begin
        next_fin_re = s_re;
        next_fin_im = s_im;
        next_fin_valid = 1'b1;
        next_acc_re = '0;
        next_acc_im = '0;
      end else begin
        next_acc_re = s_re;
        next_acc_im = s_im;
      end
    end
    if (fin_valid) begin
      next_value = (p[39:32] != 8'h00) ? 16'hFFFF : p[31:16];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx <= '0;
      acc_re <= '0;
      acc_im <= '0;
      fin_re <= '0;
      fin_im <= '0;
      fin_valid <= 1'b0;
      residual_voltage_value_o <= '0;
    end else begin
      idx <= next_idx;
      acc_re <= next_acc_re;
      acc_im <= next_acc_im;
      fin_re <= next_fin_re;
      fin_im <= next_fin_im;
      fin_valid <= next_fin_valid;
      residual_voltage_value_o <= next_value;
    end
  end

  // millisecond tick and forcing flag
  logic [MSW-1:0] ms_cnt, next_ms_cnt;
  logic tick, next_tick;
  logic [FW-1:0] force_ms, next_force_ms;
  logic next_force_flag;

  always_comb begin
    next_tick = (ms_cnt == MSW'(MS_CYCLES - 1));
    next_ms_cnt = next_tick ? '0 : ms_cnt + 1'b1;
    next_force_flag = force_flag_o;
    next_force_ms = force_ms;
    if (force_set_i && password_ok_i) begin
      next_force_flag = 1'b1;
      next_force_ms = '0;
    end else if (force_flag_o) begin
      if (force_clr_i) begin
        next_force_flag = 1'b0;
      end else if (tick) begin
        if (force_ms == FW'(FORCE_MS - 1)) begin
          next_force_flag = 1'b0;
        end else begin
          next_force_ms = force_ms + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_cnt <= '0;
      tick <= 1'b0;
      force_flag_o <= 1'b0;
      force_ms <= '0;
    end else begin
      ms_cnt <= next_ms_cnt;
      tick <= next_tick;
      force_flag_o <= next_force_flag;
      force_ms <= next_force_ms;
    end
  end

  AST_FORCE_TIMEOUT: assert property (@(posedge ref_clk_i)
    disable iff (rst_i) force_flag_o && tick && !force_set_i &&
    force_ms == FW'(FORCE_MS - 1) |=> !force_flag_o)
    else $error("forcing flag outlived its timeout");

  // settings per stage and group, group selection
  logic [15:0] pickup [NST][4], next_pickup [NST][4];
  logic [19:0] delay [NST][4], next_delay [NST][4];
  logic [1:0] manual_group, next_manual_group, next_group;

  always_comb begin
    next_pickup = pickup;
    next_delay = delay;
    next_manual_group = manual_group;
    if (set_wr_i && password_ok_i) begin
      next_pickup[set_stage_i][set_group_i] = set_pickup_i;
      next_delay[set_stage_i][set_group_i] = set_delay_ms_i;
    end
    if (manual_group_wr_i && password_ok_i) begin
      next_manual_group = manual_group_i;
    end
    case (group_select_source_i)
      residual_ov_pkg::src_digital_input: next_group = digital_group_i;
      residual_ov_pkg::src_virtual_input: next_group = virtual_input_n_i;
      residual_ov_pkg::src_indicator_lamp: next_group = indicator_lamp_n_i;
      residual_ov_pkg::src_virtual_output: next_group = virtual_output_n_i;
      default: next_group = next_manual_group;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pickup <= '{default: '{default: `PICKUP_RST}};
      delay <= '{default: '{default: `DELAY_RST}};
      manual_group <= `GROUP_RST;
      active_parameter_group_o <= `GROUP_RST;
    end else begin
      pickup <= next_pickup;
      delay <= next_delay;
      manual_group <= next_manual_group;
      active_parameter_group_o <= next_group;
    end
  end

  AST_MANUAL_GROUP: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    group_select_source_i == residual_ov_pkg::src_none && manual_group_wr_i
    && password_ok_i |=> active_parameter_group_o == $past(manual_group_i))
    else $error("manual group not taken");

  // stage state
  logic disabled;
  logic [1:0] exceed;
  logic meas_start [NST], next_meas_start [NST];
  logic meas_trip [NST], next_meas_trip [NST];
  logic forced_start [NST], next_forced_start [NST];
  logic forced_trip [NST], next_forced_trip [NST];
  logic [19:0] elapsed [NST], next_elapsed [NST];
  logic [19:0] pct_acc [NST], next_pct_acc [NST];
  logic [6:0] pct [NST], next_pct [NST];
  logic [15:0] max_v [NST], next_max_v [NST];
  logic [1:0] next_start, next_trip, ev_trip, ev_drop;
  logic [15:0] next_scnt [NST], next_tcnt [NST];
  residual_ov_pkg::stage_status_type next_status [NST];

  // comparison against the active group's pick-up
  always_comb begin
    disabled = block_i ||
      voltage_mode_i == residual_ov_pkg::single_line_to_line_mode ||
      voltage_mode_i == residual_ov_pkg::single_line_to_neutral_mode;
    for (int s = 0; s < NST; s++) begin
      exceed[s] = !disabled && residual_voltage_value_o >
        pickup[s][active_parameter_group_o];
    end
  end

  always_comb begin
    logic [19:0] dly, acc;
    dly = '0;
    acc = '0;
    for (int s = 0; s < NST; s++) begin
      dly = delay[s][active_parameter_group_o];
      acc = pct_acc[s];
      next_meas_start[s] = exceed[s];
      next_meas_trip[s] = meas_trip[s];
      next_elapsed[s] = elapsed[s];
      next_pct[s] = pct[s];
      next_max_v[s] = max_v[s];
      if (!exceed[s]) begin
        next_meas_trip[s] = 1'b0;
        next_elapsed[s] = '0;
      end else if (!meas_start[s]) begin
        next_elapsed[s] = '0;
        next_pct[s] = '0;
        acc = '0;
        next_max_v[s] = residual_voltage_value_o;
      end else begin
        if (residual_voltage_value_o > max_v[s]) begin
          next_max_v[s] = residual_voltage_value_o;
        end
        if (!meas_trip[s] && elapsed[s] >= dly) begin
          next_meas_trip[s] = 1'b1;
        end
        if (tick && !meas_trip[s]) begin
          next_elapsed[s] = elapsed[s] + 20'h0_0001;
        end
        // elapsed percent by repeated subtraction, one step a cycle
        if (dly != '0 && acc >= dly && pct[s] < `TRIP_PCT) begin
          acc = acc - dly;
          next_pct[s] = pct[s] + 7'h01;
        end
        if (tick && !meas_trip[s]) begin
          acc = acc + 20'h0_0064;
        end
      end
      next_pct_acc[s] = acc;
      // forced status only while the common flag is up
      next_forced_start[s] = forced_start[s];
      next_forced_trip[s] = forced_trip[s];
      if (!force_flag_o) begin
        next_forced_start[s] = 1'b0;
        next_forced_trip[s] = 1'b0;
      end else if (force_wr_i && force_stage_i == s[0]) begin
        next_forced_start[s] = force_start_i;
        next_forced_trip[s] = force_trip_i;
      end
      next_start[s] = next_meas_start[s] || next_forced_start[s];
      next_trip[s] = next_meas_trip[s] || next_forced_trip[s];
      // counters: an edge in the clearing cycle still counts
      next_scnt[s] = start_cnt_clr_i[s] ? '0 : start_event_counter_o[s];
      next_tcnt[s] = trip_cnt_clr_i[s] ? '0 : trip_event_counter_o[s];
      if (next_start[s] && !start_o[s]) begin
        next_scnt[s] = next_scnt[s] + 16'h0001;
      end
      if (next_trip[s] && !trip_o[s]) begin
        next_tcnt[s] = next_tcnt[s] + 16'h0001;
      end
      if (disabled) begin
        next_status[s] = residual_ov_pkg::stage_blocked;
      end else if (next_trip[s]) begin
        next_status[s] = residual_ov_pkg::stage_trip;
      end else if (next_start[s]) begin
        next_status[s] = residual_ov_pkg::stage_start;
      end else begin
        next_status[s] = residual_ov_pkg::stage_idle;
      end
      ev_trip[s] = next_meas_trip[s] && !meas_trip[s];
      ev_drop[s] = meas_start[s] && !next_meas_start[s] && !meas_trip[s];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meas_start <= '{default: 1'b0};
      meas_trip <= '{default: 1'b0};
      forced_start <= '{default: 1'b0};
      forced_trip <= '{default: 1'b0};
      elapsed <= '{default: '0};
      pct_acc <= '{default: '0};
      pct <= '{default: '0};
      max_v <= '{default: '0};
      start_o <= '0;
      trip_o <= '0;
      start_event_counter_o <= '{default: '0};
      trip_event_counter_o <= '{default: '0};
      stage_status_o <= '{default: residual_ov_pkg::stage_idle};
    end else begin
      meas_start <= next_meas_start;
      meas_trip <= next_meas_trip;
      forced_start <= next_forced_start;
      forced_trip <= next_forced_trip;
      elapsed <= next_elapsed;
      pct_acc <= next_pct_acc;
      pct <= next_pct;
      max_v <= next_max_v;
      start_o <= next_start;
      trip_o <= next_trip;
      start_event_counter_o <= next_scnt;
      trip_event_counter_o <= next_tcnt;
      stage_status_o <= next_status;
    end
  end

  AST_START_ON_EXCEED: assert property (@(posedge ref_clk_i)
    disable iff (rst_i) exceed[0] |=> start_o[0] && meas_start[0])
    else $error("low stage did not start");
  AST_DISABLED: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    voltage_mode_i == residual_ov_pkg::single_line_to_line_mode
    && !force_flag_o |=> !start_o[1] && !trip_o[1] &&
    stage_status_o[1] == residual_ov_pkg::stage_blocked)
    else $error("high stage active in single line mode");
  AST_TRIP_AFTER_DELAY: assert property (@(posedge ref_clk_i)
    disable iff (rst_i) $rose(meas_trip[0]) |->
    $past(elapsed[0]) >= $past(delay[0][active_parameter_group_o]))
    else $error("trip before delay expired");
  AST_DROP_OUT: assert property (@(posedge ref_clk_i)
    disable iff (rst_i) !exceed[1] |=> !meas_start[1] && !meas_trip[1]
    && elapsed[1] == 20'h0_0000)
    else $error("start or timer held below pick-up");
  AST_COUNT_START: assert property (@(posedge ref_clk_i)
    disable iff (rst_i) $rose(start_o[0]) && !$past(start_cnt_clr_i[0])
    |-> start_event_counter_o[0] ==
    $past(start_event_counter_o[0]) + 16'h0001)
    else $error("start counter missed an edge");
  AST_COUNT_CLEAR: assert property (@(posedge ref_clk_i)
    disable iff (rst_i) trip_cnt_clr_i[1] && !(next_trip[1] && !trip_o[1])
    |=> trip_event_counter_o[1] == 16'h0000)
    else $error("trip counter not cleared");
  AST_FORCE_REJECT: assert property (@(posedge ref_clk_i)
    disable iff (rst_i) !force_flag_o ##1 force_wr_i && !force_flag_o
    |=> !forced_start[0] && !forced_trip[0])
    else $error("forced write taken without flag");

  // fault records, only the high stage recorded when both stages finish together
  fault_rec_if #(.AW(AW)) rec ();
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [3:0] next_count;
  logic next_rec_valid;
  logic hi;

  always_comb begin
    hi = ev_trip[1] || ev_drop[1];
    rec.wr_en = (ev_trip != 2'b00) || (ev_drop != 2'b00);
    rec.wr_addr = wr_ptr;
    rec.wr_data.high_stage = hi;
    rec.wr_data.date = date_i;
    rec.wr_data.time_ms = time_ms_i;
    rec.wr_data.recorded_fault_voltage = max_v[hi];
    rec.wr_data.elapsed_delay_percent = ev_trip[hi] ? `TRIP_PCT : pct[hi];
    rec.wr_data.active_parameter_group = active_parameter_group_o;
    rec.rd_addr = wr_ptr - AW'(1) - AW'(rec_rd_idx_i);
    next_wr_ptr = rec.wr_en ? wr_ptr + AW'(1) : wr_ptr;
    next_count = (rec.wr_en && rec_count_o < 4'(DEPTH)) ?
      rec_count_o + 4'h1 : rec_count_o;
    next_rec_valid = rec_rd_i && 4'(rec_rd_idx_i) < rec_count_o;
    rec_data_o = rec.rd_data;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rec_count_o <= '0;
      rec_valid_o <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rec_count_o <= next_count;
      rec_valid_o <= next_rec_valid;
    end
  end

  AST_TRIP_RECORD: assert property (@(posedge ref_clk_i)
    disable iff (rst_i) ev_trip[0] && !ev_trip[1] && !ev_drop[1] |->
    rec.wr_en && rec.wr_data.elapsed_delay_percent == `TRIP_PCT)
    else $error("trip record not at full delay");

  fault_record_mem #(.DEPTH(DEPTH)) u_mem (
    .ref_clk_i(ref_clk_i),
    .rec(rec)
  );
endmodule

// file: logic/residual_ov_defs.svh
// constants of the residual overvoltage stages
`ifndef RESIDUAL_OV_DEFS_SVH
`define RESIDUAL_OV_DEFS_SVH
`define CLK_HZ 25000000
`define MS_PER_S 1000
`define S_PER_MIN 60
`define FORCE_TIMEOUT_MIN 5
`define TRIP_PCT 7'h64
`define PICKUP_RST 16'h03E8
`define DELAY_RST 20'h0_0064
`define GROUP_RST 2'h0
`define LAST_SAMPLE 4'hF
`define QUARTER 4'h4
`endif

// file: logic/residual_ov_pkg.sv
// types of the residual overvoltage stages
package residual_ov_pkg;
  typedef enum logic [1:0] {
    phase_calc_mode,
    residual_input_mode,
    single_line_to_line_mode,
    single_line_to_neutral_mode
  } voltage_mode_type;
  typedef enum logic [2:0] {
    src_none,
    src_digital_input,
    src_virtual_input,
    src_indicator_lamp,
    src_virtual_output
  } group_source_type;
  typedef enum logic [1:0] {
    stage_idle,
    stage_blocked,
    stage_start,
    stage_trip
  } stage_status_type;
  typedef struct packed {
    logic high_stage;
    logic [31:0] date;
    logic [26:0] time_ms;
    logic [15:0] recorded_fault_voltage;
    logic [6:0] elapsed_delay_percent;
    logic [1:0] active_parameter_group;
  } record_type;
endpackage

// file: logic/fault_rec_if.sv
// fault record store port between stage logic and memory
`timescale 1ns/1ps
interface fault_rec_if #(parameter int AW = 3);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  residual_ov_pkg::record_type wr_data;
  logic [AW-1:0] rd_addr;
  residual_ov_pkg::record_type rd_data;
  modport writer(output wr_en, output wr_addr, output wr_data,
    output rd_addr, input rd_data);
  modport store(input wr_en, input wr_addr, input wr_data,
    input rd_addr, output rd_data);
endinterface

// file: logic/fault_record_mem.sv
// memory of the latest fault records, registered read
`timescale 1ns/1ps
module fault_record_mem #(
  parameter int DEPTH = 8
)(
  // clock
  input wire logic ref_clk_i,
  // store port
  fault_rec_if.store rec
);
  residual_ov_pkg::record_type mem [DEPTH];

  // write and registered read
  always_ff @(posedge ref_clk_i) begin
    if (rec.wr_en) begin
      mem[rec.wr_addr] <= rec.wr_data;
    end
    rec.rd_data <= mem[rec.rd_addr];
  end
endmodule

// file: sim/vt_channel_model.sv
// behavioural voltage transformer channel producing residual samples
`timescale 1ns/1ps
module vt_channel_model (
  // clock
  input wire logic ref_clk_i,
  // waveform control
  input wire logic [15:0] amp_i,
  input wire logic harm3_i,
  // sample stream
  output logic signed [15:0] sample_o,
  output logic sample_valid_o
);
  int idx = 0;
  real ph;
  initial begin
    sample_o = 16'h0000;
    sample_valid_o = 1'b0;
  end
  // one sample every second cycle, sixteen per fundamental period
  always @(negedge ref_clk_i) begin
    if (!sample_valid_o) begin
      ph = 6.2831853 * idx * (harm3_i ? 3.0 : 1.0) / 16.0;
      sample_o <= 16'($rtoi($itor(amp_i) * $sin(ph)));
      sample_valid_o <= 1'b1;
      idx = (idx + 1) % 16;
    end else begin
      sample_o <= ~sample_o; // stale value not held between samples
      sample_valid_o <= 1'b0;
    end
  end
endmodule

// file: sim/test_residual_overvoltage_stages.sv
// self-checking bench of the residual overvoltage stages
`include "residual_ov_defs.svh"
`timescale 1ns/1ps
module test_residual_overvoltage_stages;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  // low phase gain keeps measured values under the default pick-up
  logic [15:0] amp = 16'h0000, gain = 16'h0080, sec = 16'hFFFF, pick;
  logic harm3 = 1'b0, blk = 1'b0, pw = 1'b0, set_wr = 1'b0, set_st = 1'b0;
  logic mwr = 1'b0, fset = 1'b0, fclr = 1'b0, fwr = 1'b0, fst = 1'b0;
  logic fstart = 1'b0, ftrip = 1'b0, rrd = 1'b0, v;
  logic [19:0] dly = 20'h0_0000;
  logic [1:0] sgrp = 2'h0, dg = 2'h0, vi = 2'h0, lp = 2'h0, vo = 2'h0;
  logic [1:0] mg = 2'h0, scl = 2'h0, tcl = 2'h0;
  logic [2:0] ridx = 3'h0;
  logic [31:0] date = 32'h0000_0000;
  logic [26:0] tms = 27'h000_0000;
  residual_ov_pkg::voltage_mode_type vm = residual_ov_pkg::phase_calc_mode;
  residual_ov_pkg::group_source_type src = residual_ov_pkg::src_none;
  logic signed [15:0] sample;
  logic sample_valid, fflag, rvalid;
  logic [15:0] value, scnt [2], tcnt [2];
  logic [1:0] start, trip, grp;
  logic [3:0] rcount;
  residual_ov_pkg::stage_status_type status [2];
  residual_ov_pkg::record_type rdata;
  int errors = 0, checks_done = 0, cyc = 0, n;
  // clock at 25 MHz
  always #20 ref_clk_i = ~ref_clk_i;
  vt_channel_model u_vt (.ref_clk_i(ref_clk_i), .amp_i(amp), .harm3_i(harm3),
    .sample_o(sample), .sample_valid_o(sample_valid));
  residual_overvoltage_stages #(.MS_CYCLES(10), .FORCE_MS(5)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sample_i(sample),
    .sample_valid_i(sample_valid), .voltage_mode_i(vm), .rated_gain_i(gain),
    .residual_transformer_secondary_i(sec), .block_i(blk),
    .password_ok_i(pw), .set_wr_i(set_wr), .set_stage_i(set_st),
    .set_group_i(sgrp), .set_pickup_i(pick), .set_delay_ms_i(dly),
    .group_select_source_i(src), .digital_group_i(dg),
    .virtual_input_n_i(vi), .indicator_lamp_n_i(lp),
    .virtual_output_n_i(vo), .manual_group_wr_i(mwr), .manual_group_i(mg),
    .force_set_i(fset), .force_clr_i(fclr), .force_wr_i(fwr),
    .force_stage_i(fst), .force_start_i(fstart), .force_trip_i(ftrip),
    .start_cnt_clr_i(scl), .trip_cnt_clr_i(tcl), .date_i(date),
    .time_ms_i(tms), .rec_rd_i(rrd), .rec_rd_idx_i(ridx),
    .residual_voltage_value_o(value), .start_o(start), .trip_o(trip),
    .stage_status_o(status), .start_event_counter_o(scnt),
    .trip_event_counter_o(tcnt), .active_parameter_group_o(grp),
    .force_flag_o(fflag), .rec_valid_o(rvalid), .rec_count_o(rcount),
    .rec_data_o(rdata));
  // expected group for a source selection
  function automatic logic [1:0] exp_grp(input int s);
    case (s)
      1: return dg;
      2: return vi;
      3: return lp;
      4: return vo;
      default: return mg;
    endcase
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask
  // one setting write, password as currently driven
  task automatic setw(input logic [15:0] p, input logic [19:0] d);
    pick = p;
    dly = d;
    set_wr = 1'b1;
    tick(1);
    set_wr = 1'b0;
  endtask
  // record read, valid must pulse for exactly one cycle
  task automatic rd(input logic [2:0] i);
    ridx = i;
    rrd = 1'b1;
    tick(1);
    v = rvalid;
    rrd = 1'b0;
    tick(1);
    v = v & !rvalid;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic results;
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end
  initial begin
    pick = 16'h0000;
    void'($urandom(94));
    date = $urandom;
    tms = 27'($urandom);
    tick(10);
    rst_i = 1'b0;
    tick(1);
    chk({start, trip, grp, fflag}, 7'h00);
    chk(scnt[0], 16'h0000);
    amp = 16'h4E20 + 16'($urandom % 10000);
    setw(16'h0001, 20'h0_0003);
    tick(80);
    chk(start, 2'b00);
    pw = 1'b1;
    harm3 = 1'b1;
    // lower the pick-up only once a pure harmonic period is seen
    tick(80);
    setw(16'h0001, 20'h0_0003);
    tick(80);
    chk(start, 2'b00);
    harm3 = 1'b0;
    for (n = 0; n < 200 && start[0] !== 1'b1; n++) tick(1);
    chk({start, scnt[0]}, {2'b01, 16'h0001});
    chk(status[0], residual_ov_pkg::stage_start);
    for (n = 0; n < 200 && trip[0] !== 1'b1; n++) tick(1);
    chk(n >= 20 && n <= 45, 1'b1);
    chk(tcnt[0], 16'h0001);
    amp = 16'h0000;
    for (n = 0; n < 200 && start[0] !== 1'b0; n++) tick(1);
    chk({start, trip}, 4'h0);
    rd(3'h0);
    chk({v, rcount}, {1'b1, 4'h1});
    chk(rdata.elapsed_delay_percent, `TRIP_PCT);
    chk({rdata.date, rdata.time_ms}, {date, tms});
    chk({rdata.active_parameter_group, rdata.high_stage}, 3'h0);
    rd(3'h5);
    chk(v, 1'b0);
    scl = 2'b01;
    tcl = 2'b01;
    tick(1);
    scl = 2'b00;
    tcl = 2'b00;
    tick(1);
    chk({scnt[0], tcnt[0]}, 32'h0000_0000);
    amp = 16'h7530;
    blk = 1'b1;
    tick(80);
    chk(start, 2'b00);
    chk(status[0], residual_ov_pkg::stage_blocked);
    blk = 1'b0;
    for (int m = 2; m < 4; m++) begin
      vm = residual_ov_pkg::voltage_mode_type'(m);
      tick(80);
      chk({start, status[0]}, {2'b00, residual_ov_pkg::stage_blocked});
    end
    vm = residual_ov_pkg::residual_input_mode;
    tick(80);
    // only the secondary scale lifts the high stage over its pick-up
    chk(start, 2'b11);
    amp = 16'h0000;
    vm = residual_ov_pkg::phase_calc_mode;
    tick(80);
    fst = 1'b0;
    fstart = 1'b1;
    pulse(fwr);
    tick(2);
    chk(start, 2'b00);
    pulse(fset);
    tick(1);
    chk(fflag, 1'b1);
    pulse(fwr);
    tick(1);
    chk(start[0], 1'b1);
    tick(30);
    chk(fflag, 1'b1);
    tick(35);
    chk({fflag, start}, 3'h0);
    fstart = 1'b0;
    mg = 2'($urandom);
    pulse(mwr);
    for (int s = 0; s < 5; s++) begin
      {dg, vi, lp, vo} = 8'($urandom);
      src = residual_ov_pkg::group_source_type'(s);
      tick(4);
      chk(grp, exp_grp(s));
    end
    results();
  end
endmodule
